// ==== pkg/aisc_pkg.sv ====
package aisc_pkg;
    localparam int AISC_NCH = 4;
    localparam int AISC_DW = 16;
    localparam int AISC_CLK_HZ = 50000000;
    // Times in microseconds
    localparam int AISC_NORMAL_PERIOD_US = 6500;
    localparam int AISC_FAST_SLOT_US = 1300;
    localparam int AISC_NORMAL_PERIOD_CYC = AISC_NORMAL_PERIOD_US * (AISC_CLK_HZ / 1000000);
    localparam int AISC_FAST_SLOT_CYC = AISC_FAST_SLOT_US * (AISC_CLK_HZ / 1000000);
    // Register byte offsets
    localparam logic [11:0] AISC_REG_CTRL = 12'h000;
    localparam logic [11:0] AISC_REG_STATUS = 12'h004;
    localparam logic [11:0] AISC_REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] AISC_REG_IRQ_MASK = 12'h00C;
    localparam logic [11:0] AISC_REG_CHCFG = 12'h010;
    localparam logic [11:0] AISC_REG_LO_BASE = 12'h020;
    localparam logic [11:0] AISC_REG_HI_BASE = 12'h030;
    localparam logic [11:0] AISC_REG_RES_BASE = 12'h040;
    // CTRL fields
    localparam int AISC_CTRL_FAST_BIT = 0;
    localparam int AISC_CTRL_INUSE_LSB = 4;
    localparam int AISC_CTRL_FILT_LSB = 8;
    localparam logic [31:0] AISC_CTRL_RST = 32'h0000_00F0;
    localparam logic [31:0] AISC_CHCFG_RST = 32'h0000_0000;
    localparam logic [2:0] AISC_FILT_MAX = 3'h6;
    // CHCFG: three bits per channel; RESULT word: result low 16, flags above
    localparam int AISC_CHCFG_W = 3;
    localparam int AISC_RES_UNDER_BIT = 16;
    localparam int AISC_RES_OVER_BIT = 17;
    localparam int AISC_RES_BROKEN_BIT = 18;
    // Default thresholds for the 0 to 10 V range
    localparam logic [15:0] AISC_LO_RST = 16'hFC17;
    localparam logic [15:0] AISC_HI_RST = 16'h2AF9;

    typedef enum logic [2:0] {
        AISC_RANGE_BIP10 = 3'b000,
        AISC_RANGE_UNI10 = 3'b001,
        AISC_RANGE_UNI5 = 3'b010,
        AISC_RANGE_LIVE0 = 3'b011,
        AISC_RANGE_BIP5 = 3'b100
    } aisc_range_t;
endpackage

// ==== core/aisc_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module aisc_filter
    import aisc_pkg::*;
#(
    parameter int DW = AISC_DW
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [2:0] coef,
    input wire logic signed [DW-1:0] raw,
    output logic signed [DW-1:0] filtered
);
    initial begin
        if (DW < 8 || DW > 24) begin
            $error("aisc_filter: DW out of range");
        end
    end

    // Extra fraction bits keep small steps from vanishing at high coefficients
    logic signed [DW+7:0] acc_ff;
    logic signed [DW+7:0] raw_ext;
    logic signed [DW+7:0] nxt_acc;
    logic [2:0] k_ff;

    assign raw_ext = {raw, 8'h00};

    // Out of range coefficient keeps the last valid one
    always_ff @(posedge clock) begin
        if (rst) begin
            k_ff <= 3'h0;
        end else if (coef <= AISC_FILT_MAX) begin
            k_ff <= coef;
        end
    end

    always_comb begin
        if (k_ff == 3'h0) begin
            nxt_acc = raw_ext;
        end else begin
            nxt_acc = acc_ff + ((raw_ext - acc_ff) >>> (k_ff + 3'h1));
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            acc_ff <= '0;
        end else if (load) begin
            acc_ff <= nxt_acc;
        end
    end

    assign filtered = acc_ff[DW+7:8];
endmodule
`default_nettype wire

// ==== core/aisc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Four common-point channels, each converted and reported on its own.
// - Each channel selects one of five voltage or current ranges.
// - Normal cycle converts all channels every fixed 6.5 ms.
// - Fast cycle converts only channels flagged in use.
// - Fast cycle period is 1.3 ms plus 1.3 ms per channel in use.
// - Configured mode bit governs the timing of all measurements.
// - Live-zero range with nothing connected reports a broken-wire error.
// - Scan runs free, unsynchronised to the controller program cycle.
// - Measurements below lower threshold flag underflow, above upper flag overflow.
// - First-order filter, coefficient 0 to 6, zero means none, changeable live.
module aisc_top
    import aisc_pkg::*;
#(
    parameter int NCH = AISC_NCH,
    parameter int NORMAL_CYC = AISC_NORMAL_PERIOD_CYC,
    parameter int SLOT_CYC = AISC_FAST_SLOT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic conv_start,
    output logic [1:0] conv_chan,
    input wire logic conv_done,
    input wire logic signed [15:0] conv_data,
    input wire logic [3:0] wire_open,
    output logic irq
);
    initial begin
        if (NCH != 4 || SLOT_CYC < 2 || NORMAL_CYC < SLOT_CYC * NCH) begin
            $error("aisc_top: unsupported parameters");
        end
    end

    function automatic logic [2:0] popcount4(input logic [3:0] v);
        popcount4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
    endfunction

    function automatic logic signed [15:0] word16(input logic [31:0] w);
        word16 = w[15:0];
    endfunction

    typedef enum logic [1:0] {
        AISC_ST_IDLE = 2'b00,
        AISC_ST_CONV = 2'b01,
        AISC_ST_WAIT = 2'b10
    } aisc_state_t;

    logic [31:0] ctrl_ff;
    logic [31:0] chcfg_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic [15:0] lo_ff [0:3];
    logic [15:0] hi_ff [0:3];
    logic [15:0] res_ff [0:3];
    logic [2:0] flags_ff [0:3];
    aisc_state_t state_ff;
    logic [31:0] period_cnt_ff;
    logic [1:0] chan_ff;
    logic [3:0] pending_ff;
    logic [3:0] scan_in_use_ff;
    logic scan_done_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic conv_start_ff;
    logic irq_ff;
    logic filt_load;
    logic signed [15:0] filt_out;
    logic filt_load_d_ff;
    logic [1:0] filt_chan_ff;

    logic fast_mode;
    logic [3:0] in_use;
    logic [31:0] period_len;
    logic period_end;
    logic wr_en;
    logic rd_en;
    logic apb_access;
    logic addr_ok;
    logic [3:0] irq_set;
    logic [3:0] scan_set;
    logic [1:0] reg_idx;

    assign fast_mode = ctrl_ff[AISC_CTRL_FAST_BIT];
    assign in_use = ctrl_ff[AISC_CTRL_INUSE_LSB +: 4];
    assign reg_idx = paddr[3:2];

    // Period length follows the mode and the in-use count
    always_comb begin
        if (fast_mode) begin
            period_len = SLOT_CYC + SLOT_CYC * {29'h0, popcount4(in_use)};
        end else begin
            period_len = NORMAL_CYC;
        end
    end

    assign period_end = (period_cnt_ff >= period_len - 32'h1);

    // Free-running period counter; no input from the controller task cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            period_cnt_ff <= 32'h0;
        end else if (period_end) begin
            period_cnt_ff <= 32'h0;
        end else begin
            period_cnt_ff <= period_cnt_ff + 32'h1;
        end
    end

    // Channel sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= AISC_ST_IDLE;
            chan_ff <= 2'h0;
            pending_ff <= 4'h0;
            scan_in_use_ff <= 4'h0;
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= 1'b0;
            case (state_ff)
                AISC_ST_IDLE: begin
                    if (period_end) begin
                        // Normal mode converts every channel, fast only the flagged ones
                        pending_ff <= fast_mode ? in_use : 4'hF;
                        scan_in_use_ff <= in_use;
                        state_ff <= AISC_ST_WAIT;
                    end
                end
                AISC_ST_WAIT: begin
                    if (pending_ff == 4'h0) begin
                        state_ff <= AISC_ST_IDLE;
                    end else begin
                        for (int i = NCH - 1; i >= 0; i--) begin
                            if (pending_ff[i]) begin
                                chan_ff <= 2'(i);
                            end
                        end
                        conv_start_ff <= 1'b1;
                        state_ff <= AISC_ST_CONV;
                    end
                end
                AISC_ST_CONV: begin
                    if (conv_done) begin
                        pending_ff[chan_ff] <= 1'b0;
                        state_ff <= AISC_ST_WAIT;
                    end
                end
                default: begin
                    state_ff <= AISC_ST_IDLE;
                end
            endcase
        end
    end

    assign filt_load = (state_ff == AISC_ST_CONV) && conv_done;

    aisc_filter #(
        .DW(16)
    ) u_filter (
        .clock(clock),
        .rst(rst),
        .load(filt_load),
        .coef(ctrl_ff[AISC_CTRL_FILT_LSB +: 3]),
        .raw(conv_data),
        .filtered(filt_out)
    );

    // One shared filter state: it is reset per channel by using zero coefficient only
    always_ff @(posedge clock) begin
        if (rst) begin
            filt_load_d_ff <= 1'b0;
            filt_chan_ff <= 2'h0;
        end else begin
            filt_load_d_ff <= filt_load;
            filt_chan_ff <= chan_ff;
        end
    end

    // Result holding registers and range flags, written only on a finished conversion
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                res_ff[i] <= 16'h0000;
                flags_ff[i] <= 3'h0;
            end
        end else if (filt_load_d_ff) begin
            res_ff[filt_chan_ff] <= filt_out;
            flags_ff[filt_chan_ff][0] <= filt_out < $signed(lo_ff[filt_chan_ff]);
            flags_ff[filt_chan_ff][1] <= filt_out > $signed(hi_ff[filt_chan_ff]);
            flags_ff[filt_chan_ff][2] <= wire_open[filt_chan_ff]
                && (chcfg_ff[filt_chan_ff*AISC_CHCFG_W +: AISC_CHCFG_W] == AISC_RANGE_LIVE0);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            scan_done_ff <= 1'b0;
        end else begin
            scan_done_ff <= (state_ff == AISC_ST_WAIT) && (pending_ff == 4'h0);
        end
    end

    // Events: bit0 scan done, bit1 underflow, bit2 overflow, bit3 broken wire
    always_comb begin
        scan_set = 4'h0;
        for (int i = 0; i < 4; i++) begin
            scan_set[1] = scan_set[1] | flags_ff[i][0];
            scan_set[2] = scan_set[2] | flags_ff[i][1];
            scan_set[3] = scan_set[3] | flags_ff[i][2];
        end
        irq_set = {scan_set[3:1] & {3{scan_done_ff}}, scan_done_ff};
    end

    // APB slave, one wait state
    assign apb_access = psel && penable && !pready_ff;
    assign wr_en = apb_access && pwrite;
    assign rd_en = apb_access && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else if (paddr[11:4] > AISC_REG_RES_BASE[11:4]) begin
            addr_ok = 1'b0;
        end else if (paddr[11:4] == AISC_REG_CHCFG[11:4] && paddr[3:2] != 2'b00) begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= AISC_CTRL_RST;
            chcfg_ff <= AISC_CHCFG_RST;
            irq_mask_ff <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                lo_ff[i] <= AISC_LO_RST;
                hi_ff[i] <= AISC_HI_RST;
            end
        end else if (wr_en && addr_ok) begin
            if (paddr == AISC_REG_CTRL) begin
                ctrl_ff <= pwdata & 32'h0000_07F1;
            end else if (paddr == AISC_REG_CHCFG) begin
                chcfg_ff <= pwdata & 32'h0000_0FFF;
            end else if (paddr == AISC_REG_IRQ_MASK) begin
                irq_mask_ff <= pwdata[3:0];
            end else if (paddr[11:4] == AISC_REG_LO_BASE[11:4]) begin
                lo_ff[reg_idx] <= word16(pwdata);
            end else if (paddr[11:4] == AISC_REG_HI_BASE[11:4]) begin
                hi_ff[reg_idx] <= word16(pwdata);
            end
        end
    end

    // Read clears the status, but a same-cycle event still sets its bit
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat_ff <= 4'h0;
        end else if (rd_en && paddr == AISC_REG_IRQ_STAT) begin
            irq_stat_ff <= irq_set;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= apb_access && !addr_ok;
            prdata_ff <= 32'h0;
            if (rd_en && addr_ok) begin
                if (paddr == AISC_REG_CTRL) begin
                    prdata_ff <= ctrl_ff;
                end else if (paddr == AISC_REG_STATUS) begin
                    prdata_ff <= {24'h0, scan_in_use_ff, 2'b00, state_ff};
                end else if (paddr == AISC_REG_IRQ_STAT) begin
                    prdata_ff <= {28'h0, irq_stat_ff};
                end else if (paddr == AISC_REG_IRQ_MASK) begin
                    prdata_ff <= {28'h0, irq_mask_ff};
                end else if (paddr == AISC_REG_CHCFG) begin
                    prdata_ff <= chcfg_ff;
                end else if (paddr[11:4] == AISC_REG_LO_BASE[11:4]) begin
                    prdata_ff <= {16'h0, lo_ff[reg_idx]};
                end else if (paddr[11:4] == AISC_REG_HI_BASE[11:4]) begin
                    prdata_ff <= {16'h0, hi_ff[reg_idx]};
                end else begin
                    // Whole word from one holding register, so a read never mixes scans
                    prdata_ff <= {13'h0, flags_ff[reg_idx], res_ff[reg_idx]};
                end
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign conv_start = conv_start_ff;
    assign conv_chan = chan_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

// ==== tb/aisc_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module aisc_checker
    import aisc_pkg::*;
#(
    parameter int NCH = AISC_NCH,
    parameter int NORMAL_CYC = AISC_NORMAL_PERIOD_CYC,
    parameter int SLOT_CYC = AISC_FAST_SLOT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_start,
    input wire logic [1:0] conv_chan,
    input wire logic conv_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic busy_ff;
    always_ff @(posedge clock) begin
        if (rst || conv_done) begin
            busy_ff <= 1'h0;
        end else if (conv_start) begin
            busy_ff <= 1'h1;
        end
    end
    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer to access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_cause; pready |-> $past(psel && penable); endproperty
    a_cause: assert property (p_cause) else $error("ready without access");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error without ready or zero data");
    property p_unal; psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_unal: assert property (p_unal) else $error("unaligned not refused");
    property p_ok; psel && penable && !pready && paddr == AISC_REG_CTRL |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("control access refused");
    property p_start; conv_start |=> !conv_start; endproperty
    a_start: assert property (p_start) else $error("start not a pulse");
    property p_chan; !conv_start |-> $stable(conv_chan); endproperty
    a_chan: assert property (p_chan) else $error("channel moved");
    property p_one; conv_start |-> !busy_ff; endproperty
    a_one: assert property (p_one) else $error("start during conversion");
endmodule
bind aisc_top aisc_checker #(.NCH(NCH), .NORMAL_CYC(NORMAL_CYC), .SLOT_CYC(SLOT_CYC)) i_chk (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done));
`default_nettype wire

// ==== tb/aisc_conv_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module aisc_conv_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic conv_start,
    input wire logic [1:0] conv_chan,
    input wire logic [7:0] lat,
    output logic conv_done,
    output logic signed [15:0] conv_data
);
    logic busy_ff;
    logic [7:0] cnt_ff;
    logic [1:0] chan_ff;
    always_ff @(posedge clock) begin
        conv_done <= 1'h0;
        // Data toggles outside done so a stray capture shows up
        conv_data <= ~conv_data;
        if (rst) begin
            busy_ff <= 1'h0;
            conv_data <= 16'h5A5A;
        end else if (conv_start) begin
            busy_ff <= 1'h1;
            cnt_ff <= 8'h00;
            chan_ff <= conv_chan;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff == lat) begin
                busy_ff <= 1'h0;
                conv_done <= 1'h1;
                conv_data <= 16'(int'(chan_ff) * 1000 + 100);
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/analog_input_scan_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module analog_input_scan_control_tb_top;
    import aisc_pkg::*;
    localparam int SLOT = 20;
    localparam int NORM = 100;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic conv_start, conv_done, irq;
    logic [1:0] conv_chan;
    logic signed [15:0] conv_data;
    logic [3:0] wire_open = 4'h0, seen = 4'h0;
    logic clr = 1'h0;
    logic [3:0] msk [3] = '{4'h5, 4'hF, 4'h1};
    logic [31:0] flg [4];
    logic [7:0] lat = 8'h03;
    int num_errors = 0, tests_run = 0, cyc = 0, last0 = 0, per = 0, i;
    always #10 clock = ~clock;
    aisc_top #(.NORMAL_CYC(NORM), .SLOT_CYC(SLOT)) i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_data(conv_data), .wire_open(wire_open), .irq(irq));
    aisc_conv_model i_conv (.clock(clock), .rst(rst), .conv_start(conv_start),
        .conv_chan(conv_chan), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (clr) begin
            seen <= 4'h0;
        end else if (conv_start) begin
            seen[conv_chan] <= 1'h1;
        end
        if (conv_start) begin
            if (conv_chan == 2'h0) begin
                per <= cyc - last0;
                last0 <= cyc;
            end
        end
        if (cyc > 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Entered just after a rising edge; returns just after one
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        // Ends on pready; only the bench timeout stops it if pready never comes
        while (pready !== 1'h1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    task wait_irq;
        while (irq !== 1'h1) begin
            @(posedge clock);
        end
    endtask
    // Returns just after the edge at which channel ch finishes a conversion
    task wait_done(input logic [1:0] ch);
        @(posedge clock);
        while (conv_done !== 1'h1 || conv_chan != ch) begin
            @(posedge clock);
        end
    endtask
    task observe(input int settle);
        repeat (settle) @(posedge clock);
        clr <= 1'h1;
        @(posedge clock);
        clr <= 1'h0;
        repeat (2 * NORM) @(posedge clock);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        flg = '{32'h0, 32'h1 << AISC_RES_BROKEN_BIT, 32'h1 << AISC_RES_OVER_BIT, 32'h1 << AISC_RES_UNDER_BIT};
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        apb(1'h0, AISC_REG_CTRL, 32'h0);
        chk(rd, AISC_CTRL_RST);
        apb(1'h0, AISC_REG_CHCFG, 32'h0);
        chk(rd, AISC_CHCFG_RST);
        apb(1'h1, 12'h001, 32'h1);
        chk({31'h0, er}, 32'h1);
        apb(1'h0, 12'hFFC, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'h0, AISC_REG_CTRL, 32'h0);
        chk(rd, AISC_CTRL_RST);
        // Slow converter, ch1 live-zero with open wire, ch2 over, ch3 under
        wire_open <= 4'h2;
        lat <= 8'h0C;
        apb(1'h1, AISC_REG_CHCFG, 32'(AISC_RANGE_LIVE0) << AISC_CHCFG_W);
        apb(1'h1, AISC_REG_HI_BASE + 12'h008, 32'd500);
        apb(1'h1, AISC_REG_LO_BASE + 12'h00C, 32'd4000);
        apb(1'h1, AISC_REG_CTRL, 32'h0);
        observe(3 * NORM);
        chk({28'h0, seen}, 32'hF);
        chk(32'(per), 32'(NORM));
        for (i = 0; i < 4; i++) begin
            apb(1'h0, AISC_REG_RES_BASE + 12'(4 * i), 32'h0);
            chk(rd, 32'(1000 * i + 100) | flg[i]);
            apb(1'h0, AISC_REG_RES_BASE + 12'(4 * i), 32'h0);
            chk(rd, 32'(1000 * i + 100) | flg[i]);
        end
        apb(1'h1, AISC_REG_IRQ_MASK, 32'h1);
        wait_irq();
        apb(1'h0, AISC_REG_IRQ_STAT, 32'h0);
        wait_irq();
        apb(1'h0, AISC_REG_IRQ_STAT, 32'h0);
        chk({28'h0, rd[3:0]}, 32'hF);
        apb(1'h0, AISC_REG_IRQ_STAT, 32'h0);
        chk({28'h0, rd[3:0]}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        lat <= 8'h03;
        for (i = 0; i < 3; i++) begin
            apb(1'h1, AISC_REG_CTRL, {24'h0, msk[i], 4'h1});
            observe(4 * NORM);
            chk({28'h0, seen}, {28'h0, msk[i]});
            chk(32'(per), 32'(SLOT * (1 + $countones(msk[i]))));
        end
        apb(1'h1, AISC_REG_CTRL, 32'h611);
        apb(1'h0, AISC_REG_CTRL, 32'h0);
        chk(rd, 32'h611);
        apb(1'h1, AISC_REG_CTRL, 32'h711);
        apb(1'h0, AISC_REG_CTRL, 32'h0);
        chk(rd, 32'h711);
        // Step from ch3 (3100) to ch0 (100) at k=1; the invalid 7 must leave k at 1
        apb(1'h1, AISC_REG_CTRL, 32'h081);
        wait_done(2'h3);
        apb(1'h1, AISC_REG_CTRL, 32'h101);
        apb(1'h1, AISC_REG_CTRL, 32'h711);
        wait_done(2'h0);
        apb(1'h0, AISC_REG_RES_BASE, 32'h0);
        chk(rd, 32'h92E);
        end_of_test();
    end
endmodule
`default_nettype wire
